//--- hw/ccr_channel_config.sv
module ccr_channel_config (
	input  wire logic                                 clk,
	input  wire logic                                 rstn,
	input  wire logic                                 cfg_wr,
	input  wire logic [2:0]                           cfg_page,
	input  wire logic [15:0]                          cfg_wdata,
	output logic [15:0]                               cfg_rdata,
	input  wire logic                                 first_control_pin,
	input  wire logic                                 second_control_pin,
	input  wire ccr_pkg::ccr_stat_s [ccr_pkg::NCH-1:0] chan_stat,
	output ccr_pkg::ccr_ctrl_s [ccr_pkg::NCH-1:0]      chan_ctrl
);

	// ==========================================================
	// Reset release
	// ==========================================================

	logic [1:0] rst_q;  // Reset release shift stages.
	logic       srst_n; // Synchronised reset, active low.

	// Reset is asserted at once and released after two clock edges.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end

	assign srst_n = rst_q[1];

	// ==========================================================
	// State and next state
	// ==========================================================

	ccr_pkg::ccr_state_s st_r;   // Registered state.
	ccr_pkg::ccr_state_s st_nxt; // Next state.

	// Computes the whole next state from the current one.
	always_comb
	begin
		logic [15:0]      c;
		logic             win;
		logic             dm00;
		logic             warn;
		ccr_pkg::ccr_dac_e dm;
		c    = 16'h0000;
		win  = 1'b0;
		dm00 = 1'b0;
		warn = 1'b0;
		dm   = ccr_pkg::CCR_DAC_SERVO;
		st_nxt = st_r;
		// Pins come from outside and pass two stages first.
		st_nxt.pin1 = {second_control_pin, first_control_pin};
		st_nxt.pin2 = st_r.pin1;
		// paged read
		// The read word follows the paged channel one cycle later.
		st_nxt.rdata = st_r.cfg[cfg_page];
		// reserved bits
		// Reserved bits are never stored, so they read as zero.
		if (cfg_wr)
		begin
			st_nxt.cfg[cfg_page] = cfg_wdata & ccr_pkg::WR_MASK;
		end
		for (int i = 0; i < ccr_pkg::NCH; i++)
		begin
			// per-channel word
			// Each channel decodes only its own word.
			c    = st_r.cfg[i];
			dm   = ccr_pkg::ccr_dac_e'(c[ccr_pkg::B_DAC_H:ccr_pkg::B_DAC_L]);
			// active window
			// DAC connect and servo act only while on and after the rise time.
			win  = chan_stat[i].on && chan_stat[i].rise_done;
			dm00 = win && (dm == ccr_pkg::CCR_DAC_SERVO);
			warn = chan_stat[i].ov_warn || chan_stat[i].uv_warn;
			// sequencing mode
			// Upper bit set means tracking slave, else lower bit picks turn-off.
			st_nxt.ctrl[i].track_slave = c[ccr_pkg::B_MODE_H];
			st_nxt.ctrl[i].seq_off = !c[ccr_pkg::B_MODE_H] && c[ccr_pkg::B_MODE_L];
			st_nxt.ctrl[i].fast_servo = !c[ccr_pkg::B_FSOFF];
			st_nxt.ctrl[i].sup_coarse = c[ccr_pkg::B_SUP];
			// odd channel resolution
			// Even channels stay at coarse resolution whatever is stored.
			st_nxt.ctrl[i].adc_fine = (i % 2 == 1) && c[ccr_pkg::B_ADC];
			st_nxt.ctrl[i].fmt_l11_mv = (i % 2 == 1) && c[ccr_pkg::B_ADC];
			st_nxt.ctrl[i].control = c[ccr_pkg::B_CSEL] ? st_r.pin2[1] : st_r.pin2[0];
			// servo parking
			// Outside the window the park flag clears for a fresh servo.
			if (!dm00 || c[ccr_pkg::B_CONT])
				st_nxt.hold[i] = 1'b0;
			// re-servo on warning
			// A warning releases the park so the loop returns to nominal.
			else if (c[ccr_pkg::B_WARN] && warn)
				st_nxt.hold[i] = 1'b0;
			else if (chan_stat[i].target_hit)
				st_nxt.hold[i] = 1'b1;
			st_nxt.ctrl[i].servo_run = dm00 && (c[ccr_pkg::B_CONT] || !st_nxt.hold[i]);
			// DAC connection
			// Modes 00 and 11 soft-connect; mode 10 connects at once.
			st_nxt.ctrl[i].dac_soft = win && !chan_stat[i].soft_done &&
				(dm == ccr_pkg::CCR_DAC_SERVO || dm == ccr_pkg::CCR_DAC_SOFT);
			st_nxt.ctrl[i].dac_now = win && (dm == ccr_pkg::CCR_DAC_NOW);
			// code write gate
			// In mode 11 a new code waits for soft-connect to finish.
			st_nxt.ctrl[i].dac_wr_ok = (dm != ccr_pkg::CCR_DAC_SOFT) ||
				chan_stat[i].soft_done;
			st_nxt.ctrl[i].en_wpu = chan_stat[i].on && (i < ccr_pkg::PIN_LIM) &&
				c[ccr_pkg::B_WPU];
			// weak pull-down
			// Soft stops on channels below PIN_LIM use the weak pull-down; faults never do.
			st_nxt.ctrl[i].en_wpd = !chan_stat[i].on && !chan_stat[i].off_fault &&
				(i < ccr_pkg::PIN_LIM) && c[ccr_pkg::B_WPD];
			st_nxt.ctrl[i].en_fpd = !chan_stat[i].on && !st_nxt.ctrl[i].en_wpd;
			st_nxt.ctrl[i].gain_hi = c[ccr_pkg::B_GAIN];
			st_nxt.ctrl[i].dac_noninv = c[ccr_pkg::B_POL];
		end
	end

	// Registers the state; every word returns to its reset value.
	always_ff @(posedge clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			st_r <= '0;
			st_r.cfg <= {ccr_pkg::NCH{ccr_pkg::CFG_RST}};
		end
		else
			st_r <= st_nxt;
	end

	assign cfg_rdata = st_r.rdata;
	assign chan_ctrl = st_r.ctrl;

	// ==========================================================
	// Checks on the register path
	// ==========================================================

	a_rsv_zero: assert property (@(posedge clk) disable iff (!srst_n)
		cfg_rdata[13:12] == 2'h0)
		else $error("reserved bits read nonzero");

	a_write_back: assert property (@(posedge clk) disable iff (!srst_n)
		cfg_wr ##1 $stable(cfg_page) |=> cfg_rdata == ($past(cfg_wdata, 2) & ccr_pkg::WR_MASK))
		else $error("paged word did not read back");

	// ==========================================================
	// Checks per channel
	// ==========================================================

	for (genvar g = 0; g < ccr_pkg::NCH; g++)
	begin : g_chk
		a_chan_isolate: assert property (@(posedge clk) disable iff (!srst_n)
			cfg_wr && cfg_page != 3'(g) |=> $stable(st_r.cfg[g]))
			else $error("write disturbed another channel");

		a_track_mode: assert property (@(posedge clk) disable iff (!srst_n)
			##1 chan_ctrl[g].track_slave == $past(st_r.cfg[g][15]))
			else $error("tracking decode wrong");

		a_ctl_select: assert property (@(posedge clk) disable iff (!srst_n)
			##1 chan_ctrl[g].control ==
			$past(st_r.cfg[g][8] ? st_r.pin2[1] : st_r.pin2[0]))
			else $error("control pin select wrong");

		// The antecedents below also ask for the sampled released reset: an attempt
		// that starts at the release edge would otherwise look at controls that are
		// still at their reset value one edge later.
		a_soft_gate: assert property (@(posedge clk) disable iff (!srst_n)
			srst_n && st_r.cfg[g][5:4] == 2'h3 && !chan_stat[g].soft_done
			|=> !chan_ctrl[g].dac_wr_ok)
			else $error("code write allowed before soft-connect");

		a_fast_pd: assert property (@(posedge clk) disable iff (!srst_n)
			srst_n &&
			!chan_stat[g].on && (chan_stat[g].off_fault || !st_r.cfg[g][2])
			|=> chan_ctrl[g].en_fpd && !chan_ctrl[g].en_wpd)
			else $error("fast pull-down missing");

		a_servo_park: assert property (@(posedge clk) disable iff (!srst_n)
			srst_n && st_r.hold[g] && !st_r.cfg[g][7] &&
			!(chan_stat[g].ov_warn || chan_stat[g].uv_warn)
			|=> !chan_ctrl[g].servo_run)
			else $error("servo ran while parked");

		if (g % 2 == 0)
		begin : g_even
			a_adc_even: assert property (@(posedge clk) disable iff (!srst_n)
				!chan_ctrl[g].adc_fine && !chan_ctrl[g].fmt_l11_mv)
				else $error("even channel at fine resolution");
		end

		if (g >= ccr_pkg::PIN_LIM)
		begin : g_hi
			a_pull_mask: assert property (@(posedge clk) disable iff (!srst_n)
				!chan_ctrl[g].en_wpu && !chan_ctrl[g].en_wpd)
				else $error("weak pin driver on upper channel");
		end
	end

endmodule : ccr_channel_config

//--- hw/ccr_pkg.sv
package ccr_pkg;

	// ==========================================================
	// Channel count and field layout
	// ==========================================================

	localparam int          NCH      = 8;        // Channels, one configuration word each.
	localparam int          PIN_LIM  = 4;        // First channel without weak pin drivers.
	localparam int          B_MODE_H = 15;       // Sequencing mode, upper bit.
	localparam int          B_MODE_L = 14;       // Sequencing mode, lower bit.
	localparam int          B_FSOFF  = 11;       // Fast servo disable.
	localparam int          B_SUP    = 10;       // Supervisor coarse scale.
	localparam int          B_ADC    = 9;        // Fine ADC resolution, odd channels.
	localparam int          B_CSEL   = 8;        // Control pin select.
	localparam int          B_CONT   = 7;        // Continuous servo.
	localparam int          B_WARN   = 6;        // Re-servo on warning.
	localparam int          B_DAC_H  = 5;        // DAC mode, upper bit.
	localparam int          B_DAC_L  = 4;        // DAC mode, lower bit.
	localparam int          B_WPU    = 3;        // Weak pull-up on enable pin.
	localparam int          B_WPD    = 2;        // Weak pull-down on enable pin.
	localparam int          B_GAIN   = 1;        // DAC buffer gain.
	localparam int          B_POL    = 0;        // DAC polarity.
	localparam logic [15:0] WR_MASK  = 16'hcfff; // Bits 13:12 are reserved.
	localparam logic [15:0] CFG_RST  = 16'h0000; // Word value after reset.

	// ==========================================================
	// DAC usage modes
	// ==========================================================

	typedef enum logic [1:0] {
		CCR_DAC_SERVO = 2'h0, // Soft-connect if needed, then servo.
		CCR_DAC_OFF   = 2'h1, // DAC left disconnected.
		CCR_DAC_NOW   = 2'h2, // Connect at once with the stored code.
		CCR_DAC_SOFT  = 2'h3  // Soft-connect only.
	} ccr_dac_e;

	// ==========================================================
	// Per-channel carriers
	// ==========================================================

	// Status that the channel engines report, on the same clock.
	typedef struct packed {
		logic on;          // Channel is in the on state.
		logic off_fault;   // Channel was turned off by a fault.
		logic rise_done;   // Rise time has elapsed.
		logic soft_done;   // DAC soft-connect has completed.
		logic target_hit;  // Servo target reached.
		logic ov_warn;     // Output at or above overvoltage warning limit.
		logic uv_warn;     // Output at or below undervoltage warning limit.
	} ccr_stat_s;

	// Decoded controls handed to the channel engines.
	typedef struct packed {
		logic track_slave; // Channel tracks a master supply.
		logic seq_off;     // Sequenced turn-off on fault.
		logic fast_servo;  // Fast servo allowed.
		logic sup_coarse;  // Supervisor at 8mV/LSB, 6.0V range.
		logic adc_fine;    // ADC at 15.6uV/LSB.
		logic fmt_l11_mv;  // Output reading in eleven-bit linear, millivolts.
		logic control;     // Level of the selected control pin.
		logic servo_run;   // Servo loop active.
		logic dac_soft;    // Request a DAC soft-connect.
		logic dac_now;     // Connect DAC at once.
		logic dac_wr_ok;   // A new DAC code may be written.
		logic en_wpu;      // Weak pull-up on enable pin.
		logic en_fpd;      // Fast pull-down on enable pin.
		logic en_wpd;      // Weak pull-down on enable pin.
		logic gain_hi;     // DAC 2.65V full scale.
		logic dac_noninv;  // Noninverting trim polarity.
	} ccr_ctrl_s;

	// Whole state of the block.
	typedef struct packed {
		logic [NCH-1:0][15:0]  cfg;   // Configuration words.
		logic [15:0]           rdata; // Read word of the paged channel.
		logic [1:0]            pin1;  // Control pins, first sync stage.
		logic [1:0]            pin2;  // Control pins, second sync stage.
		logic [NCH-1:0]        hold;  // Target reached, servo parked.
		ccr_ctrl_s [NCH-1:0]   ctrl;  // Registered controls.
	} ccr_state_s;

endpackage : ccr_pkg

//--- tb/ccr_host.sv
// ==========================================================
// Host model that issues configuration writes and page selects
// ==========================================================
module ccr_host (
	input  wire logic  clk,
	output logic       cfg_wr,
	output logic [2:0] cfg_page,
	output logic [15:0] cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// The port starts idle with no write pending.
	initial
	begin
		cfg_wr = 1'h0;
		cfg_page = 3'h0;
		cfg_wdata = 16'h0000;
	end

	// One word per write; the data line then shows the inverse so stale data never matches.
	task automatic wr(input logic [2:0] p, input logic [15:0] d);
		@(negedge clk);
		cfg_wr = 1'h1;
		cfg_page = p;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'h0;
		cfg_wdata = ~d;
	endtask : wr

	// A page change alone selects which word is read back.
	task automatic sel(input logic [2:0] p);
		@(negedge clk);
		cfg_page = p;
	endtask : sel
endmodule : ccr_host

//--- tb/tb.sv
// ==========================================================
// Self-checking bench for the channel configuration words
// ==========================================================
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     clk, rstn, p1, p2, cfg_wr;
	logic [2:0]               cfg_page;
	logic [15:0]              cfg_wdata, cfg_rdata;
	ccr_pkg::ccr_stat_s [7:0] stat;  // Engine status driven by the bench.
	ccr_pkg::ccr_ctrl_s [7:0] ctrl;  // Decoded controls from the design.
	int                       fails, n_compared, cycles, ch;
	logic [15:0]              wr_word;  // Random word handed to the host.
	int                       mem [8];  // Expected word of each channel.

	ccr_host ccr_host_inst (.clk(clk), .cfg_wr(cfg_wr), .cfg_page(cfg_page), .cfg_wdata(cfg_wdata));
	ccr_channel_config ccr_channel_config_inst (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr),
		.cfg_page(cfg_page), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.first_control_pin(p1), .second_control_pin(p2), .chan_stat(stat), .chan_ctrl(ctrl));

	// Expected controls of one channel while no servo target has been reached.
	function automatic ccr_pkg::ccr_ctrl_s model(input int c);
		ccr_pkg::ccr_ctrl_s e;
		logic [15:0]        w;
		logic               win, low;
		int                 m;
		w = mem[c][15:0];
		win = stat[c].on & stat[c].rise_done;
		low = (c < 4);
		m = w[5:4];
		e.track_slave = w[15];
		e.seq_off = ~w[15] & w[14];
		e.fast_servo = ~w[11];
		e.sup_coarse = w[10];
		e.adc_fine = w[9] & (c % 2 == 1);
		e.fmt_l11_mv = e.adc_fine;
		e.control = w[8] ? p2 : p1;
		e.servo_run = win & (m == 0);
		e.dac_soft = win & ~stat[c].soft_done & (m == 0 || m == 3);
		e.dac_now = win & (m == 2);
		e.dac_wr_ok = (m != 3) | stat[c].soft_done;
		e.en_wpu = stat[c].on & w[3] & low;
		e.en_wpd = ~stat[c].on & ~stat[c].off_fault & w[2] & low;
		e.en_fpd = ~stat[c].on & ~e.en_wpd;
		e.gain_hi = w[1];
		e.dac_noninv = w[0];
		return e;
	endfunction : model

	// Compares a read word or a single flag widened to a word.
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// Compares the whole control bundle of one channel with the model.
	task automatic chk_ctrl(input int c);
		n_compared++;
		if (ctrl[c] !== model(c))
		begin
			fails++;
			$display("CHECK FAILED %0t channel %0d controls %h", $time, c, ctrl[c]);
		end
	endtask : chk_ctrl

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// Free-running 25 MHz clock.
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// Cuts a hung run short.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			wrap_up();
		end
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		rstn = 1'h0;
		p1 = 1'h0;
		p2 = 1'h0;
		stat = '0;
		void'($urandom(23));
		foreach (mem[i]) mem[i] = 0;
		repeat (8) @(negedge clk);
		rstn = 1'h1;
		repeat (3) @(negedge clk);
		chk_word(cfg_rdata, 16'h0000);
		for (int i = 0; i < 8; i++) chk_ctrl(i);
		// Random words, status and pin levels on random channels.
		repeat (60)
		begin
			ch = $urandom_range(7);
			wr_word = 16'($urandom);
			mem[ch] = int'(wr_word & ccr_pkg::WR_MASK);
			ccr_host_inst.wr(3'(ch), wr_word);
			stat = 56'({$urandom, $urandom});
			for (int i = 0; i < 8; i++) stat[i].target_hit = 1'h0;
			p1 = 1'($urandom);
			p2 = 1'($urandom);
			repeat (4) @(negedge clk);
			for (int i = 0; i < 8; i++) chk_ctrl(i);
			// Read back a channel picked afresh; the page may stay on the same channel.
			ch = $urandom_range(7);
			ccr_host_inst.sel(3'(ch));
			repeat (2) @(negedge clk);
			chk_word(cfg_rdata, mem[ch][15:0]);
		end
		// Servo on channel 0: stops at target, restarts on a warning.
		ccr_host_inst.wr(3'h0, 16'h0040);
		stat = '0;
		stat[0].on = 1'h1;
		stat[0].rise_done = 1'h1;
		stat[0].soft_done = 1'h1;
		repeat (4) @(negedge clk);
		chk_word({15'h0000, ctrl[0].servo_run}, 16'h0001);
		stat[0].target_hit = 1'h1;
		@(negedge clk);
		stat[0].target_hit = 1'h0;
		repeat (3) @(negedge clk);
		chk_word({15'h0000, ctrl[0].servo_run}, 16'h0000);
		stat[0].ov_warn = 1'h1;
		@(negedge clk);
		stat[0].ov_warn = 1'h0;
		repeat (3) @(negedge clk);
		chk_word({15'h0000, ctrl[0].servo_run}, 16'h0001);
		// Continuous servo keeps running after the target.
		ccr_host_inst.wr(3'h0, 16'h0080);
		stat[0].target_hit = 1'h1;
		repeat (4) @(negedge clk);
		chk_word({15'h0000, ctrl[0].servo_run}, 16'h0001);
		// In mode 10 channel 1 connects the DAC at once when on and past the rise time.
		ccr_host_inst.wr(3'h1, 16'h0020);
		mem[1] = 32'h00000020;
		stat[1].on = 1'h1;
		stat[1].rise_done = 1'h1;
		repeat (2) @(negedge clk);
		chk_ctrl(1);
		// A second reset in mid-run returns every word and control to rest.
		stat = '0;
		rstn = 1'h0;
		repeat (2) @(negedge clk);
		rstn = 1'h1;
		foreach (mem[i]) mem[i] = int'(ccr_pkg::CFG_RST);
		repeat (5) @(negedge clk);
		chk_word(cfg_rdata, ccr_pkg::CFG_RST);
		for (int i = 0; i < 8; i++) chk_ctrl(i);
		wrap_up();
	end
endmodule : tb
